// ---- rtl/scr_link_shift.sv ----
// slave serial shifter clocked by the host's serial clock
// assumes word stays stable from a req toggle until ack follows it
module scr_link_shift
    import scr_pkg::*;
#(
    parameter int WORD_W = scr_pkg::RES_W
) (
    // link clock and system reset
    input  wire logic              serial_data_clock,
    input  wire logic              sys_rst,
    // hand-over from the system domain
    input  wire logic [WORD_W-1:0] word,
    input  wire logic              req_tgl,
    output logic                   ack_tgl_ff,
    // serial data
    output logic                   sdo_ff
);
    logic              rst_s1_ff;
    logic              rst_s2_ff;
    logic              req_s1_ff;
    logic              req_s2_ff;
    logic [WORD_W-1:0] shreg_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              load;

    // a new word is taken only between words, so a frame is never torn
    assign load = (cnt_ff == '0) && (req_s2_ff != ack_tgl_ff);

    always_ff @(posedge serial_data_clock) begin
        rst_s1_ff <= sys_rst;
        rst_s2_ff <= rst_s1_ff;
        req_s1_ff <= req_tgl;
        req_s2_ff <= req_s1_ff;
    end

    always_ff @(posedge serial_data_clock) begin
        if (rst_s2_ff) begin
            shreg_ff   <= '0;
            cnt_ff     <= '0;
            sdo_ff     <= 1'b0;
            ack_tgl_ff <= 1'b0;
        end else if (load) begin
            sdo_ff     <= word[WORD_W-1];
            shreg_ff   <= {word[WORD_W-2:0], 1'b0};
            cnt_ff     <= CNT_W'(WORD_W - 1);
            ack_tgl_ff <= req_s2_ff;
        end else if (cnt_ff != '0) begin
            sdo_ff     <= shreg_ff[WORD_W-1];
            shreg_ff   <= {shreg_ff[WORD_W-2:0], 1'b0};
            cnt_ff     <= cnt_ff - 1'b1;
        end
    end

    AST_SLAVE_SHIFT: assert property (@(posedge serial_data_clock)
        disable iff (rst_s2_ff)
        (cnt_ff != '0) |=> sdo_ff == $past(shreg_ff[WORD_W-1]))
        else $error("slave data out did not take the next bit");

    AST_SLAVE_MSB: assert property (@(posedge serial_data_clock)
        disable iff (rst_s2_ff)
        load |=> sdo_ff == $past(word[WORD_W-1]) && cnt_ff == WORD_W - 1)
        else $error("slave word did not start with its top bit");
endmodule

// ---- rtl/scr_sync3.sv ----
// three-stage synchroniser with agreement filter
// assumes d comes from another clock domain or a pin
module scr_sync3 #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] nxt_q;

    // a bit only moves once the last two stages agree
    assign nxt_q = (s2_ff & s3_ff) | (q & (s2_ff | s3_ff));

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q     <= RST_VAL;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q     <= nxt_q;
        end
    end
endmodule

// ---- rtl/scr_top.sv ----
// conversion sequencer, parallel bus and serial readout timing
// assumes adc_result is valid from the system clock domain at all times
module scr_top #(
    parameter int WORD_W = scr_pkg::RES_W
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    // host strobes (pins)
    input  wire logic                      convert_start_n,
    input  wire logic                      chip_select_n,
    input  wire logic                      read_n,
    // configuration (pins)
    input  wire logic                      serial_sel,
    input  wire logic                      master_sel,
    input  wire logic                      read_after_sel,
    input  wire logic                      warp_sel,
    input  wire logic                      impulse_sel,
    input  wire logic [1:0]                serial_clock_divider,
    // converter core
    input  wire logic [WORD_W-1:0]         adc_result,
    // link clock from the host
    input  wire logic                      serial_data_clock,
    // status and parallel bus
    output logic                           busy,
    output logic [WORD_W-1:0]              data_bus,
    output logic                           data_oe,
    // serial port
    output logic                           frame_sync,
    output logic                           frame_sync_oe,
    output logic                           serial_clk_out,
    output logic                           serial_clk_oe,
    output logic                           serial_data_out,
    output logic                           serial_data_oe
);
    import scr_pkg::*;

    // ==========================================================
    // input synchronisers
    logic [CTL_W-1:0] ctl_raw;
    logic [CTL_W-1:0] ctl_q;
    logic [CFG_W-1:0] cfg_raw;
    logic [CFG_W-1:0] cfg_q;
    logic             ack_raw;
    logic             ack_q;

    assign ctl_raw = {read_n, chip_select_n, convert_start_n};
    assign cfg_raw = {serial_clock_divider, impulse_sel, warp_sel,
                      read_after_sel, master_sel, serial_sel};

    scr_sync3 #(.WIDTH(CTL_W), .RST_VAL(CTL_RST)) u_ctl_sync (
        .clk (mclk),
        .rst (sys_rst),
        .d   (ctl_raw),
        .q   (ctl_q)
    );

    scr_sync3 #(.WIDTH(CFG_W), .RST_VAL(CFG_RST)) u_cfg_sync (
        .clk (mclk),
        .rst (sys_rst),
        .d   (cfg_raw),
        .q   (cfg_q)
    );

    scr_sync3 #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
        .clk (mclk),
        .rst (sys_rst),
        .d   (ack_raw),
        .q   (ack_q)
    );

    // ==========================================================
    // decoded configuration
    logic                cnv_lvl;
    logic                cs_low;
    logic                rd_low;
    logic                is_ser;
    logic                is_mst;
    logic                master_rac;
    logic                master_rdc;
    logic [1:0]          div;
    scr_mode_t           mode;
    logic [CNT_W-1:0]    busy_cyc;
    logic [CNT_W-1:0]    conv_cyc;
    logic [CNT_W-1:0]    rdc_dly;
    logic [CNT_W-1:0]    rac_dly;
    logic [HALF_W-1:0]   half_sel;

    assign cnv_lvl    = ctl_q[CTL_CNV];
    assign cs_low     = ~ctl_q[CTL_CS];
    assign rd_low     = ~ctl_q[CTL_RD];
    assign is_ser     = cfg_q[CFG_SER];
    assign is_mst     = cfg_q[CFG_MST];
    assign master_rac = is_ser & is_mst & cfg_q[CFG_RAC];
    assign master_rdc = is_ser & is_mst & ~cfg_q[CFG_RAC];
    assign div        = cfg_q[CFG_DIV+1:CFG_DIV];
    // both mode pins high falls back to normal
    assign mode = (cfg_q[CFG_WRP] & ~cfg_q[CFG_IMP]) ? MODE_WARP :
                  (~cfg_q[CFG_WRP] & cfg_q[CFG_IMP]) ? MODE_IMPULSE :
                  MODE_NORMAL;
    assign busy_cyc = (mode == MODE_WARP)    ? BUSY_WARP_CYC :
                      (mode == MODE_IMPULSE) ? BUSY_IMP_CYC : BUSY_NORM_CYC;
    assign conv_cyc = busy_cyc - EOC_CYC;
    assign rdc_dly  = (mode == MODE_WARP)    ? RDC_WARP_CYC :
                      (mode == MODE_IMPULSE) ? RDC_IMP_CYC : RDC_NORM_CYC;
    assign rac_dly  = (mode == MODE_WARP)    ? RAC_WARP_CYC :
                      (mode == MODE_IMPULSE) ? RAC_IMP_CYC : RAC_NORM_CYC;
    assign half_sel = (div == 2'h0) ? HALF0_CYC :
                      (div == 2'h1) ? HALF1_CYC :
                      (div == 2'h2) ? HALF2_CYC : HALF3_CYC;

    // ==========================================================
    // conversion sequencer
    scr_state_t        state_ff;
    scr_state_t        nxt_state;
    logic              cnv_prev_ff;
    logic [CNT_W-1:0]  elapsed_ff;
    logic [WORD_W-1:0] data_word_ff;
    logic              busy_ff;
    logic              cnv_fall;
    logic              conv_done;
    logic              frm_start;
    logic              frm_end;
    logic              frm_ff;

    // strobes during a conversion are ignored; the host must space them
    assign cnv_fall  = cnv_prev_ff & ~cnv_lvl;
    assign conv_done = (state_ff == ST_CONV) && (elapsed_ff == conv_cyc);
    assign frm_start = ((state_ff == ST_CONV) && master_rdc &&
                        (elapsed_ff == rdc_dly)) ||
                       ((state_ff == ST_WAIT) && (elapsed_ff >= rac_dly));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (cnv_fall) nxt_state = ST_CONV;
            ST_CONV: if (conv_done) nxt_state = ST_EOC;
            ST_EOC:  nxt_state = master_rac ? ST_WAIT : ST_IDLE;
            ST_WAIT: if (frm_start) nxt_state = ST_XFER;
            ST_XFER: if (frm_end) nxt_state = ST_TAIL;
            ST_TAIL: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff    <= ST_IDLE;
            cnv_prev_ff <= 1'b1;
            elapsed_ff  <= '0;
            busy_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnv_prev_ff <= cnv_lvl;
            busy_ff     <= (nxt_state != ST_IDLE);
            if (state_ff == ST_IDLE)
                elapsed_ff <= CNT_W'(1);
            else if (elapsed_ff != '1)
                elapsed_ff <= elapsed_ff + 1'b1;
        end
    end

    // result lands a full cycle before busy falls
    always_ff @(posedge mclk) begin
        if (sys_rst)
            data_word_ff <= '0;
        else if (conv_done)
            data_word_ff <= adc_result;
    end

    // ==========================================================
    // parallel bus and pin enables
    logic data_oe_ff;
    logic mst_oe_ff;
    logic sdo_oe_ff;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_oe_ff <= 1'b0;
            mst_oe_ff  <= 1'b0;
            sdo_oe_ff  <= 1'b0;
        end else begin
            data_oe_ff <= ~is_ser & cs_low & rd_low;
            mst_oe_ff  <= is_ser & is_mst & cs_low;
            sdo_oe_ff  <= is_ser & cs_low;
        end
    end

    // ==========================================================
    // master serial frame
    logic              sclk_ff;
    logic [HALF_W-1:0] half_ff;
    logic [CNT_W-1:0]  bits_ff;
    logic [WORD_W-1:0] fshreg_ff;
    logic              sdo_m_ff;
    logic              half_end;
    logic              fall_edge;

    assign half_end  = frm_ff && (half_ff == '0);
    assign fall_edge = half_end && sclk_ff;
    assign frm_end   = fall_edge && (bits_ff == '0);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            frm_ff  <= 1'b0;
            sclk_ff <= 1'b0;
            half_ff <= '0;
            bits_ff <= '0;
        end else if (frm_start && !frm_ff) begin
            frm_ff  <= 1'b1;
            sclk_ff <= 1'b0;
            half_ff <= half_sel - 1'b1;
            bits_ff <= CNT_W'(WORD_W - 1);
        end else if (half_end) begin
            sclk_ff <= ~sclk_ff;
            half_ff <= half_sel - 1'b1;
            if (frm_end)
                frm_ff <= 1'b0;
            else if (fall_edge)
                bits_ff <= bits_ff - 1'b1;
        end else if (frm_ff) begin
            half_ff <= half_ff - 1'b1;
        end
    end

    // read-during-convert sends the previous result, read-after the new one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fshreg_ff <= '0;
            sdo_m_ff  <= 1'b0;
        end else if (frm_start && !frm_ff) begin
            sdo_m_ff  <= data_word_ff[WORD_W-1];
            fshreg_ff <= {data_word_ff[WORD_W-2:0], 1'b0};
        end else if (fall_edge && !frm_end) begin
            sdo_m_ff  <= fshreg_ff[WORD_W-1];
            fshreg_ff <= {fshreg_ff[WORD_W-2:0], 1'b0};
        end
    end

    // ==========================================================
    // hand-over to the slave link
    logic              new_ff;
    logic              req_ff;
    logic [WORD_W-1:0] xfer_word_ff;
    logic              xfer_load;
    logic              sdo_s;

    assign xfer_load = new_ff && (ack_q == req_ff);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            new_ff       <= 1'b0;
            req_ff       <= 1'b0;
            xfer_word_ff <= '0;
        end else begin
            new_ff <= conv_done | (new_ff & ~xfer_load);        // set wins
            if (xfer_load) begin
                xfer_word_ff <= data_word_ff;
                req_ff       <= ~req_ff;
            end
        end
    end

    scr_link_shift #(.WORD_W(WORD_W)) u_link (
        .serial_data_clock (serial_data_clock),
        .sys_rst           (sys_rst),
        .word              (xfer_word_ff),
        .req_tgl           (req_ff),
        .ack_tgl_ff        (ack_raw),
        .sdo_ff            (sdo_s)
    );

    // ==========================================================
    // outputs
    assign busy            = busy_ff;
    assign data_bus        = data_word_ff;
    assign data_oe         = data_oe_ff;
    assign frame_sync      = frm_ff;
    assign frame_sync_oe   = mst_oe_ff;
    assign serial_clk_out  = sclk_ff;
    assign serial_clk_oe   = mst_oe_ff;
    // both sources are flops; the select is a quasi-static pin
    assign serial_data_out = is_mst ? sdo_m_ff : sdo_s;
    assign serial_data_oe  = sdo_oe_ff;

    // ==========================================================
    // checks
    logic [CNT_W-1:0] busy_len_ff;

    always_ff @(posedge mclk) begin
        if (sys_rst || !busy_ff)
            busy_len_ff <= '0;
        else if (busy_len_ff != '1)
            busy_len_ff <= busy_len_ff + 1'b1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_BUSY_RISE: assert property (
        (state_ff == ST_IDLE && cnv_fall) |=> busy_ff && elapsed_ff == 1)
        else $error("busy did not rise after the strobe");
    AST_BUSY_MAX: assert property (
        (busy_ff && !master_rac && $stable(mode)) |-> busy_len_ff < busy_cyc)
        else $error("busy held past the mode limit");
    AST_EOC_GAP: assert property (
        conv_done |=> busy_ff ##1 (busy_ff == master_rac))
        else $error("busy fell too close to end of conversion");
    AST_DATA_FIRST: assert property (
        ($fell(busy_ff) && !is_ser) |-> $stable(data_word_ff))
        else $error("result changed as busy fell");
    AST_BUS_OE: assert property (
        ##1 data_oe_ff == $past(~is_ser & cs_low & rd_low))
        else $error("bus enable does not follow the request");
    AST_MST_DRIVE: assert property (
        (is_ser && is_mst && cs_low) |=> mst_oe_ff && sdo_oe_ff)
        else $error("master outputs not driven under chip select");
    AST_RELEASE: assert property (
        !cs_low |=> !mst_oe_ff && !sdo_oe_ff)
        else $error("serial outputs not released");
    AST_RDC_SYNC: assert property (
        (state_ff == ST_CONV && master_rdc && elapsed_ff == rdc_dly && !frm_ff)
        |=> frm_ff && $rose(frm_ff))
        else $error("read-during-convert sync late");
    AST_RAC_SYNC: assert property (
        ($rose(frm_ff) && master_rac) |-> $past(elapsed_ff) >= rac_dly)
        else $error("read-after-convert sync early");
    AST_SCLK_SLOW: assert property (
        ($changed(sclk_ff) && div == 2'h3 && frm_ff) |=> $stable(sclk_ff))
        else $error("serial clock half period too short");
    AST_BUSY_TAIL: assert property (
        ($fell(frm_ff) && state_ff == ST_TAIL) |=> $fell(busy_ff))
        else $error("busy did not drop after frame sync");
    AST_FRAME_BITS: assert property (
        $rose(frm_ff) |-> bits_ff == WORD_W - 1 && sclk_ff == 1'b0)
        else $error("frame did not start at the top bit");
endmodule

// ---- shared/scr_pkg.sv ----
// conversion sequencer and result readout: shared constants and types
// assumes a 10 MHz system clock; all times but CNV_TO_BUSY_NS, DATA_TO_BUSY_NS and SYNC_TO_BUSY_NS are turned into whole cycles
package scr_pkg;

    // ==========================================================
    // clock and conversion
    localparam int CLK_NS = 100;
    localparam int RES_W  = 14;
    localparam int CNT_W  = 8;
    localparam int HALF_W = 2;

    function automatic int cyc_floor(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction

    function automatic int cyc_ceil(input int ns);
        return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    typedef enum logic [1:0] {MODE_NORMAL, MODE_IMPULSE, MODE_WARP} scr_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CONV, ST_EOC, ST_WAIT, ST_XFER, ST_TAIL
    } scr_state_t;

    // ==========================================================
    // timing figures
    localparam int CNV_TO_BUSY_NS  = 35;
    localparam int BUSY_WARP_NS    = 850;
    localparam int BUSY_NORM_NS    = 1100;
    localparam int BUSY_IMP_NS     = 1350;
    localparam int EOC_TO_BUSY_NS  = 10;
    localparam int DATA_TO_BUSY_NS = 20;
    localparam int RDC_WARP_NS     = 50;
    localparam int RDC_NORM_NS     = 290;
    localparam int RDC_IMP_NS      = 530;
    localparam int RAC_WARP_NS     = 710;
    localparam int RAC_NORM_NS     = 950;
    localparam int RAC_IMP_NS      = 1190;
    localparam int SYNC_TO_BUSY_NS = 25;
    localparam int SCLK_P0_NS      = 30;
    localparam int SCLK_P1_NS      = 60;
    localparam int SCLK_P2_NS      = 120;
    localparam int SCLK_P3_NS      = 240;

    localparam logic [CNT_W-1:0] BUSY_WARP_CYC = CNT_W'(cyc_floor(BUSY_WARP_NS));
    localparam logic [CNT_W-1:0] BUSY_NORM_CYC = CNT_W'(cyc_floor(BUSY_NORM_NS));
    localparam logic [CNT_W-1:0] BUSY_IMP_CYC  = CNT_W'(cyc_floor(BUSY_IMP_NS));
    localparam logic [CNT_W-1:0] EOC_CYC       = CNT_W'(cyc_ceil(EOC_TO_BUSY_NS));
    localparam logic [CNT_W-1:0] RDC_WARP_CYC  = CNT_W'(cyc_floor(RDC_WARP_NS));
    localparam logic [CNT_W-1:0] RDC_NORM_CYC  = CNT_W'(cyc_floor(RDC_NORM_NS));
    localparam logic [CNT_W-1:0] RDC_IMP_CYC   = CNT_W'(cyc_floor(RDC_IMP_NS));
    localparam logic [CNT_W-1:0] RAC_WARP_CYC  = CNT_W'(cyc_floor(RAC_WARP_NS));
    localparam logic [CNT_W-1:0] RAC_NORM_CYC  = CNT_W'(cyc_floor(RAC_NORM_NS));
    localparam logic [CNT_W-1:0] RAC_IMP_CYC   = CNT_W'(cyc_floor(RAC_IMP_NS));
    localparam logic [HALF_W-1:0] HALF0_CYC = HALF_W'(cyc_ceil(SCLK_P0_NS / 2));
    localparam logic [HALF_W-1:0] HALF1_CYC = HALF_W'(cyc_ceil(SCLK_P1_NS / 2));
    localparam logic [HALF_W-1:0] HALF2_CYC = HALF_W'(cyc_ceil(SCLK_P2_NS / 2));
    localparam logic [HALF_W-1:0] HALF3_CYC = HALF_W'(cyc_ceil(SCLK_P3_NS / 2));

    // ==========================================================
    // synchronised input vectors
    localparam int CTL_CNV = 0;
    localparam int CTL_CS  = 1;
    localparam int CTL_RD  = 2;
    localparam int CTL_W   = 3;
    localparam logic [CTL_W-1:0] CTL_RST = 3'h7;
    localparam int CFG_SER = 0;
    localparam int CFG_MST = 1;
    localparam int CFG_RAC = 2;
    localparam int CFG_WRP = 3;
    localparam int CFG_IMP = 4;
    localparam int CFG_DIV = 5;
    localparam int CFG_W   = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;

endpackage

// ---- sim/scr_host_model.sv ----
// host model: clocks the slave link and shifts in what it reads
// assumes go rises once per read; the link clock stands still between
module scr_host_model (
    // control and link
    input  wire logic        go,
    input  wire logic        sdo,
    output logic             sclk = 1'b0,
    output logic [13:0]      word
);
    timeunit 1ns;
    timeprecision 1ps;
    // two lead edges carry the hand-over across before the load edge
    always @(posedge go) begin
        repeat (16) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
            word = {word[12:0], sdo};
        end
    end
endmodule

// ---- sim/scr_top_tb.sv ----
// bench: conversions, parallel reads, master and slave serial reads
// assumes scr_host_model clocks the link and collects the slave word
module scr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scr_pkg::*;
    localparam int HS [4] = '{HALF0_CYC, HALF1_CYC, HALF2_CYC, HALF3_CYC};
    logic        mclk = 1'b0;
    logic        sys_rst, convert_start_n, chip_select_n, read_n, go;
    logic        serial_sel, master_sel, read_after_sel, warp_sel, busy;
    logic        impulse_sel, data_oe, frame_sync, frame_sync_oe, prev;
    logic        serial_clk_out, serial_clk_oe, serial_data_out, b_end;
    logic        serial_data_oe, serial_data_clock;
    logic [1:0]  serial_clock_divider;
    logic [13:0] adc_result, data_bus, hword, got;
    wire logic [2:0] oes = {frame_sync_oe, serial_clk_oe, serial_data_oe};
    int          bad_count = 0, n_compared = 0, i, w;
    scr_top dut (
        .mclk                 (mclk),
        .sys_rst              (sys_rst),
        .convert_start_n      (convert_start_n),
        .chip_select_n        (chip_select_n),
        .read_n               (read_n),
        .serial_sel           (serial_sel),
        .master_sel           (master_sel),
        .read_after_sel       (read_after_sel),
        .warp_sel             (warp_sel),
        .impulse_sel          (impulse_sel),
        .serial_clock_divider (serial_clock_divider),
        .adc_result           (adc_result),
        .serial_data_clock    (serial_data_clock),
        .busy                 (busy),
        .data_bus             (data_bus),
        .data_oe              (data_oe),
        .frame_sync           (frame_sync),
        .frame_sync_oe        (frame_sync_oe),
        .serial_clk_out       (serial_clk_out),
        .serial_clk_oe        (serial_clk_oe),
        .serial_data_out      (serial_data_out),
        .serial_data_oe       (serial_data_oe)
    );
    scr_host_model host (.go(go), .sdo(serial_data_out),
        .sclk(serial_data_clock), .word(hword));
    initial forever #50 mclk = ~mclk;
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [13:0] got_v, logic [13:0] exp_v);
        n_compared++;
        if (got_v !== exp_v) begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, got_v, exp_v);
        end
    endtask
    // strobe held low for three edges so the pin filter sees it
    task automatic strobe();
        @(posedge mclk) convert_start_n <= 1'b0;
        repeat (3) @(posedge mclk);
        convert_start_n <= 1'b1;
    endtask
    task automatic par_conv(input logic [1:0] md, int ew, logic [13:0] v);
        @(posedge mclk) {serial_sel, warp_sel, impulse_sel, adc_result}
            <= {1'b0, md, v};
        strobe();
        for (i = 0; i < 6 && busy !== 1'b1; i++) @(negedge mclk);
        chk(14'(busy), 14'h1);
        for (w = 0; w < 400 && busy === 1'b1; w++) begin
            got = data_bus;
            @(negedge mclk);
        end
        chk(14'(w), 14'(ew));
        chk(got, v);
        @(posedge mclk) {chip_select_n, read_n} <= 2'h0;
        for (i = 0; i < 8 && data_oe !== 1'b1; i++) @(negedge mclk);
        chk(14'(data_oe), 14'h1);
        chk(data_bus, v);
        @(posedge mclk) {chip_select_n, read_n} <= 2'h3;
        repeat (8) @(negedge mclk);
        chk(14'(data_oe), 14'h0);
    endtask
    // rac low reads during convert, so e is the previous result
    task automatic mst_read(input logic [1:0] dv, logic rac, logic [13:0] v,
                            logic [13:0] e);
        @(posedge mclk) {serial_sel, master_sel, read_after_sel, warp_sel,
            impulse_sel, serial_clock_divider, chip_select_n, adc_result}
            <= {2'h3, rac, 2'h2, dv, 1'b0, v};
        repeat (8) @(negedge mclk);
        chk(14'(oes), 14'h7);
        strobe();
        for (i = 0; i < 40 && frame_sync !== 1'b1; i++) @(negedge mclk);
        prev = 1'b0;
        w = 0;
        for (i = 0; i < 80 && frame_sync === 1'b1; i++) begin
            if (serial_clk_out === 1'b1 && prev === 1'b0)
                got = {got[12:0], serial_data_out};
            w += (serial_clk_out === 1'b1);
            prev = serial_clk_out;
            @(negedge mclk);
        end
        b_end = busy;
        @(negedge mclk);
        chk(14'({b_end, busy}), {12'h0, rac, 1'b0});
        chk(got, e);
        chk(14'(w), 14'(14 * HS[dv]));
        @(posedge mclk) chip_select_n <= 1'b1;
        repeat (8) @(negedge mclk);
        chk(14'(oes), 14'h0);
    endtask
    task automatic slv_read(input logic [13:0] v);
        @(posedge mclk) {serial_sel, chip_select_n, adc_result} <= {2'h2, v};
        strobe();
        repeat (30) @(posedge mclk);
        go <= 1'b1;
        #1100;
        chk(hword, v);
        @(posedge mclk) go <= 1'b0;
    endtask
    initial begin
        {sys_rst, convert_start_n, chip_select_n, read_n, go} = 5'h1e;
        {serial_sel, master_sel, read_after_sel, warp_sel} = 4'h0;
        {impulse_sel, serial_clock_divider, adc_result} = 17'h0;
        @(posedge mclk) go <= 1'b1;
        repeat (12) @(posedge mclk);
        {sys_rst, go} <= 2'h0;
        repeat (4) @(posedge mclk);
        slv_read(14'h1e69);
        par_conv(2'h2, BUSY_WARP_CYC, 14'h2a5c);
        par_conv(2'h0, BUSY_NORM_CYC, 14'h15a3);
        par_conv(2'h1, BUSY_IMP_CYC, 14'h3fff);
        par_conv(2'h3, BUSY_NORM_CYC, 14'h0001);
        for (int k = 0; k < 4; k++)
            mst_read(2'(k), 1'b1, 14'h2c35 ^ 14'(k), 14'h2c35 ^ 14'(k));
        mst_read(2'h0, 1'b0, 14'h1234, 14'h2c36);
        finish_test();
    end
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end
endmodule
